// ===== core/trim_consts.svh
`ifndef TRIM_CONSTS_SVH
`define TRIM_CONSTS_SVH

// register indices; byte address on the bus is four times the index
`define IDX_CORE3_D_OFFSET  10'h33a
`define IDX_CORE4_OFFSET    10'h33c
`define IDX_CORE5_OFFSET    10'h33e
`define IDX_CORE0_GAIN      10'h360
`define IDX_CORE1_GAIN      10'h361
`define IDX_CORE2_A_GAIN    10'h362
`define IDX_CORE2_B_GAIN    10'h363
`define IDX_CORE3_C_GAIN    10'h364
`define IDX_CORE3_D_GAIN    10'h365

// storage entry numbers, also the fuse store word addresses
`define ENT_CORE3_D_OFFSET  0
`define ENT_CORE4_OFFSET    1
`define ENT_CORE5_OFFSET    2
`define ENT_CORE0_GAIN      3
`define ENT_CORE1_GAIN      4
`define ENT_CORE2_A_GAIN    5
`define ENT_CORE2_B_GAIN    6
`define ENT_CORE3_C_GAIN    7
`define ENT_CORE3_D_GAIN    8
`define NUM_ENTRIES         9
`define NUM_OFFSET_ENTRIES  3
`define LAST_ENTRY          4'h8
`define ENTRY_W             4

// field layout
`define TRIM_WORD_W         16
`define OFFSET_VAL_MSB      11
`define GAIN_VAL_MSB        4
`define OFFSET_REG_MASK     16'hffff
`define GAIN_REG_MASK       16'h00ff
`define TRIM_RESET          16'h0000

// bus layout
`define PADDR_W             12
`define PADDR_MSB           11
`define WORD_LSB            2
`define IDX_W               10
`define PRDATA_PAD          16'h0000

`endif

// ===== core/trim_pkg.sv
`default_nettype none
`include "trim_consts.svh"

package trim_pkg;

  typedef logic [`TRIM_WORD_W-1:0]                    trim_word_t;
  typedef logic [`NUM_ENTRIES-1:0][`TRIM_WORD_W-1:0]  trim_bank_t;
  typedef logic [`ENTRY_W-1:0]                        entry_t;
  typedef logic [`OFFSET_VAL_MSB:0]                   offset_val_t;
  typedef logic [`GAIN_VAL_MSB:0]                     gain_val_t;
  typedef logic [`IDX_W-1:0]                          reg_idx_t;

  typedef enum logic [2:0] {
    FUSE_REQ,
    FUSE_WAIT,
    FUSE_CAPT,
    FUSE_FIN,
    FUSE_IDLE
  } fuse_state_t;

endpackage : trim_pkg

`default_nettype wire

// ===== core/trim_load_if.sv
`timescale 1ns/10ps
`default_nettype none

interface trim_load_if;
  import trim_pkg::*;

  logic       ld_valid;
  entry_t     ld_entry;
  trim_word_t ld_data;
  logic       load_done;

  modport loader (
    output ld_valid,
    output ld_entry,
    output ld_data,
    output load_done
  );

  modport bank (
    input  ld_valid,
    input  ld_entry,
    input  ld_data,
    input  load_done
  );
endinterface : trim_load_if

`default_nettype wire

// ===== core/fuse_loader.sv
`timescale 1ns/10ps
`default_nettype none
`include "trim_consts.svh"

module fuse_loader
  import trim_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  output var  logic              fuse_rd_en,
  output var  trim_pkg::entry_t  fuse_addr,
  input  wire trim_pkg::trim_word_t fuse_rdata,
  trim_load_if.loader            ld
);

  fuse_state_t state_q;
  fuse_state_t state_d;
  entry_t      cnt_q;
  logic        last_w;

  assign last_w = (cnt_q == `LAST_ENTRY);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      FUSE_REQ:  state_d = FUSE_WAIT;
      FUSE_WAIT: state_d = FUSE_CAPT;
      FUSE_CAPT: state_d = last_w ? FUSE_FIN : FUSE_REQ;
      FUSE_FIN:  state_d = FUSE_IDLE;
      default:   state_d = FUSE_IDLE;
    endcase
  end

  // the store answers one cycle after the read strobe, so a word is caught two edges after the request
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_q      <= FUSE_REQ;
      cnt_q        <= '0;
      fuse_rd_en   <= 1'b0;
      fuse_addr    <= '0;
      ld.ld_valid  <= 1'b0;
      ld.ld_entry  <= '0;
      ld.ld_data   <= `TRIM_RESET;
      ld.load_done <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      fuse_rd_en  <= (state_q == FUSE_REQ);
      ld.ld_valid <= (state_q == FUSE_CAPT);
      if (state_q == FUSE_REQ)
        fuse_addr <= cnt_q;
      if (state_q == FUSE_CAPT)
      begin
        ld.ld_entry <= cnt_q;
        ld.ld_data  <= fuse_rdata;
        cnt_q       <= cnt_q + 4'h1;
      end
      // done set on the same edge as the last load reaches storage
      if (state_q == FUSE_FIN)
        ld.load_done <= 1'b1;
    end
  end

endmodule : fuse_loader

`default_nettype wire

// ===== core/trim_apply.sv
`timescale 1ns/10ps
`default_nettype none
`include "trim_consts.svh"

module trim_apply
  import trim_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire trim_pkg::trim_bank_t  bank,
  input  wire logic                  core2_sel_b,
  input  wire logic                  core3_sel_d,
  input  wire trim_pkg::offset_val_t core3_c_offset_ext,
  output var  trim_pkg::gain_val_t   core0_gain_value,
  output var  trim_pkg::gain_val_t   core1_gain_value,
  output var  trim_pkg::gain_val_t   core2_gain_applied,
  output var  trim_pkg::gain_val_t   core3_gain_applied,
  output var  trim_pkg::offset_val_t core3_offset_applied,
  output var  trim_pkg::offset_val_t core4_offset_value,
  output var  trim_pkg::offset_val_t core5_offset_value
);

  gain_val_t   core2_gain_w;
  gain_val_t   core3_gain_w;
  offset_val_t core3_offset_w;

  // reserved bits never reach a core, whatever software left in them
  assign core2_gain_w   = core2_sel_b ? bank[`ENT_CORE2_B_GAIN][`GAIN_VAL_MSB:0]
                                      : bank[`ENT_CORE2_A_GAIN][`GAIN_VAL_MSB:0];
  assign core3_gain_w   = core3_sel_d ? bank[`ENT_CORE3_D_GAIN][`GAIN_VAL_MSB:0]
                                      : bank[`ENT_CORE3_C_GAIN][`GAIN_VAL_MSB:0];
  assign core3_offset_w = core3_sel_d ? bank[`ENT_CORE3_D_OFFSET][`OFFSET_VAL_MSB:0]
                                      : core3_c_offset_ext;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      core0_gain_value     <= '0;
      core1_gain_value     <= '0;
      core2_gain_applied   <= '0;
      core3_gain_applied   <= '0;
      core3_offset_applied <= '0;
      core4_offset_value   <= '0;
      core5_offset_value   <= '0;
    end
    else
    begin
      core0_gain_value     <= bank[`ENT_CORE0_GAIN][`GAIN_VAL_MSB:0];
      core1_gain_value     <= bank[`ENT_CORE1_GAIN][`GAIN_VAL_MSB:0];
      core2_gain_applied   <= core2_gain_w;
      core3_gain_applied   <= core3_gain_w;
      core3_offset_applied <= core3_offset_w;
      // unsigned value, passed without sign handling
      core4_offset_value   <= bank[`ENT_CORE4_OFFSET][`OFFSET_VAL_MSB:0];
      core5_offset_value   <= bank[`ENT_CORE5_OFFSET][`OFFSET_VAL_MSB:0];
    end
  end

endmodule : trim_apply

`default_nettype wire

// ===== core/adc_trim_regs.sv
// What this block does
// - offset trim registers are 16 bits: value in 11:0, reserved 15:12
// - core 3 uses its D offset trim only while sampling input D
// - cores 4 and 5 each use their own single offset trim always
// - gain trim registers are 8 bits: value in 4:0, reserved 7:5
// - core 2 picks gain trim A or B by its selected input
// - core 3 picks gain trim C or D by its selected input
// - every trim register resets to zero then loads its fuse default
// - offset trim values are unsigned binary
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "trim_consts.svh"

module adc_trim_regs
  import trim_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  output var  logic                  fuse_rd_en,
  output var  trim_pkg::entry_t      fuse_addr,
  input  wire trim_pkg::trim_word_t  fuse_rdata,
  output var  logic                  trim_loaded,
  input  wire logic                  core2_sel_b,
  input  wire logic                  core3_sel_d,
  input  wire trim_pkg::offset_val_t core3_c_offset_ext,
  output var  trim_pkg::gain_val_t   core0_gain_value,
  output var  trim_pkg::gain_val_t   core1_gain_value,
  output var  trim_pkg::gain_val_t   core2_gain_applied,
  output var  trim_pkg::gain_val_t   core3_gain_applied,
  output var  trim_pkg::offset_val_t core3_offset_applied,
  output var  trim_pkg::offset_val_t core4_offset_value,
  output var  trim_pkg::offset_val_t core5_offset_value
);

  localparam reg_idx_t [`NUM_ENTRIES-1:0] ENTRY_IDX = {
    `IDX_CORE3_D_GAIN,
    `IDX_CORE3_C_GAIN,
    `IDX_CORE2_B_GAIN,
    `IDX_CORE2_A_GAIN,
    `IDX_CORE1_GAIN,
    `IDX_CORE0_GAIN,
    `IDX_CORE5_OFFSET,
    `IDX_CORE4_OFFSET,
    `IDX_CORE3_D_OFFSET
  };

  trim_load_if ld ();

  trim_bank_t                bank_w;
  reg_idx_t                  word_idx_w;
  logic [`NUM_ENTRIES-1:0]   hit_w;
  logic [`NUM_ENTRIES-1:0]   wr_hit_w;
  logic [`NUM_ENTRIES-1:0]   ld_hit_w;
  logic                      mapped_w;
  logic                      answer_w;
  logic                      commit_w;
  trim_word_t                rd_word_w;
  logic                      pready_d;
  logic [31:0]               prdata_d;
  logic                      pslverr_d;

  fuse_loader u_fuse_loader (
    .clk        (clk),
    .rst_b      (rst_b),
    .fuse_rd_en (fuse_rd_en),
    .fuse_addr  (fuse_addr),
    .fuse_rdata (fuse_rdata),
    .ld         (ld.loader)
  );

  assign word_idx_w = paddr[`PADDR_MSB:`WORD_LSB];
  assign mapped_w   = |hit_w;

  // no answer until the fuse defaults sit in storage, so software never sees the plain reset zero
  assign answer_w  = psel && !pready && ld.load_done;
  assign commit_w  = psel && penable && pready && pwrite && mapped_w;
  assign pready_d  = answer_w;
  assign pslverr_d = answer_w && !mapped_w;
  assign prdata_d  = (answer_w && !pwrite) ? {`PRDATA_PAD, rd_word_w} : '0;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_ENTRIES; gi++)
    begin : g_entry
      // reserved bits are read/write storage; only the value field drives a core
      localparam trim_word_t MASK = (gi < `NUM_OFFSET_ENTRIES) ? `OFFSET_REG_MASK : `GAIN_REG_MASK;
      trim_word_t entry_q;
      trim_word_t wr_word_w;

      assign hit_w[gi]    = (word_idx_w == ENTRY_IDX[gi]);
      assign wr_hit_w[gi] = commit_w && hit_w[gi];
      assign ld_hit_w[gi] = ld.ld_valid && (ld.ld_entry == entry_t'(gi));
      assign wr_word_w    = {pstrb[1] ? pwdata[15:8] : entry_q[15:8],
                             pstrb[0] ? pwdata[7:0]  : entry_q[7:0]} & MASK;
      assign bank_w[gi]   = entry_q;

      always_ff @(posedge clk)
      begin
        if (!rst_b)
          entry_q <= `TRIM_RESET;
        else if (ld_hit_w[gi])
          entry_q <= ld.ld_data & MASK;
        else if (wr_hit_w[gi])
          entry_q <= wr_word_w;
      end
    end
  endgenerate

  always_comb
  begin
    rd_word_w = `TRIM_RESET;
    for (int i = 0; i < `NUM_ENTRIES; i++)
    begin
      if (hit_w[i])
        rd_word_w = bank_w[i];
    end
  end

  // answer registered one cycle after psel; pready drops on the completing edge
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= '0;
      trim_loaded <= 1'b0;
    end
    else
    begin
      pready      <= pready_d;
      pslverr     <= pslverr_d;
      prdata      <= prdata_d;
      trim_loaded <= ld.load_done;
    end
  end

  trim_apply u_trim_apply (
    .clk                  (clk),
    .rst_b                (rst_b),
    .bank                 (bank_w),
    .core2_sel_b          (core2_sel_b),
    .core3_sel_d          (core3_sel_d),
    .core3_c_offset_ext   (core3_c_offset_ext),
    .core0_gain_value     (core0_gain_value),
    .core1_gain_value     (core1_gain_value),
    .core2_gain_applied   (core2_gain_applied),
    .core3_gain_applied   (core3_gain_applied),
    .core3_offset_applied (core3_offset_applied),
    .core4_offset_value   (core4_offset_value),
    .core5_offset_value   (core5_offset_value)
  );

endmodule : adc_trim_regs

`default_nettype wire

// ===== verification/adc_trim_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none

module adc_trim_regs_chk
  import trim_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst_b,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  fuse_rd_en,
  input wire trim_pkg::entry_t      fuse_addr,
  input wire logic                  trim_loaded,
  input wire trim_pkg::offset_val_t core4_offset_value
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence fuse_first;
    fuse_rd_en && fuse_addr == 4'h0 ##1 !fuse_rd_en [*2];
  endsequence
  sequence fuse_second;
    fuse_rd_en && fuse_addr == 4'h1;
  endsequence

  AST_FUSE_ORDER: assert property ($rose(rst_b) |=> fuse_first ##1 fuse_second)
    else $error("fuse reads out of order after reset");
  AST_LOAD_TIME: assert property ($rose(rst_b) |-> ##28 !trim_loaded ##1 trim_loaded)
    else $error("fuse load completion at wrong cycle");
  AST_STALL: assert property (!trim_loaded |-> !pready)
    else $error("bus answered before fuse load");
  AST_ZERO_WAIT: assert property (psel && !penable && trim_loaded |=> pready)
    else $error("missing zero-wait answer");
  AST_PULSE: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside access or too long");
  AST_UPPER: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("read data above register width");
  AST_GAIN_W: assert property (pready && !pwrite && paddr[11:2] >= 10'h360 |-> prdata[15:8] == 8'h00)
    else $error("gain register wider than 8 bits");
  AST_ERR_DATA: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("error answer with data");
  AST_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  AST_ADC4_OFFSET_TRIM: assert property ($changed(core4_offset_value) |->
                             !$past(trim_loaded, 2) || ($past(pready, 2) && $past(pwrite, 2)))
    else $error("core4 offset changed without cause");
endmodule : adc_trim_regs_chk

bind adc_trim_regs adc_trim_regs_chk adc_trim_regs_chk_i (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .fuse_rd_en(fuse_rd_en), .fuse_addr(fuse_addr),
  .trim_loaded(trim_loaded), .core4_offset_value(core4_offset_value)
);

`default_nettype wire

// ===== verification/adc_trim_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "trim_consts.svh"

module adc_trim_regs_tb;
  import trim_pkg::*;
  logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, fuse_rd_en, trim_loaded, er, sel_b = 0, sel_d = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'h0, strb = 4'hf;
  entry_t      fuse_addr;
  trim_word_t  fuse_rdata = 16'h0000;
  offset_val_t ext = 12'h5a5, o3, o4, o5;
  gain_val_t   g0, g1, g2, g3;
  int          err_count = 0, checks = 0, i, s;
  reg_idx_t    idx [9] = '{`IDX_CORE3_D_OFFSET, `IDX_CORE4_OFFSET, `IDX_CORE5_OFFSET, `IDX_CORE0_GAIN,
                          `IDX_CORE1_GAIN, `IDX_CORE2_A_GAIN, `IDX_CORE2_B_GAIN, `IDX_CORE3_C_GAIN,
                          `IDX_CORE3_D_GAIN};
  trim_word_t  fz [9] = '{16'h0abc, 16'h0def, 16'h0456, 16'h0011, 16'h0012, 16'h0013, 16'h0014, 16'h0015,
                          16'h0016};
  // reserved fields always written as zero
  trim_word_t  wv [9] = '{16'h0fff, 16'h0001, 16'h0800, 16'h001f, 16'h0000, 16'h000a, 16'h0015, 16'h0003,
                          16'h001c};

  adc_trim_regs adc_trim_regs_i (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fuse_rd_en(fuse_rd_en), .fuse_addr(fuse_addr), .fuse_rdata(fuse_rdata), .trim_loaded(trim_loaded),
    .core2_sel_b(sel_b), .core3_sel_d(sel_d), .core3_c_offset_ext(ext), .core0_gain_value(g0),
    .core1_gain_value(g1), .core2_gain_applied(g2), .core3_gain_applied(g3), .core3_offset_applied(o3),
    .core4_offset_value(o4), .core5_offset_value(o5)
  );

  always #2 clk = ~clk;

  // fuse store: one-cycle latency, data garbled when not read
  always @(posedge clk)
    if (fuse_rd_en)
      fuse_rdata <= fz[fuse_addr];
    else
      fuse_rdata <= ~fuse_rdata;

  task close_out;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task apb(input logic w, input reg_idx_t x, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {x, 2'b00};
    pwdata <= d;
    pstrb <= w ? strb : 4'h0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_count++;
      $display("BAD pready expected 1 seen %b", pready);
      close_out();
    end
  endtask : apb

  initial
  begin
    repeat (10) @(posedge clk);
    chk("reset_outputs", 64'h0, {pready, trim_loaded, o4, g0, prdata});
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    // no offset calibration runs here, so offset trims may be accessed at any time
    for (i = 0; i < 9; i++)
    begin
      apb(1'b0, idx[i], 32'h0);
      chk("fuse_default", {1'b0, 16'h0, fz[i]}, {er, rd});
      apb(1'b1, idx[i], {16'h0, wv[i]});
      apb(1'b0, idx[i], 32'h0);
      chk("readback", {1'b0, 16'h0, wv[i]}, {er, rd});
    end
    // data differs from entry 0, so a misdecoded write would show
    apb(1'b1, 10'h33b, 32'h0000_0123);
    chk("unmapped_write", {1'b1, 32'h0}, {er, rd});
    apb(1'b0, 10'h33b, 32'h0);
    chk("unmapped_read", {1'b1, 32'h0}, {er, rd});
    apb(1'b0, idx[0], 32'h0);
    chk("kept_after_unmapped", {16'h0, wv[0]}, rd);
    for (s = 0; s < 2; s++)
    begin
      @(posedge clk);
      sel_b <= s[0];
      sel_d <= ~s[0];
      repeat (3) @(posedge clk);
      chk("core2_gain", s ? wv[6][4:0] : wv[5][4:0], g2);
      chk("core3_gain", s ? wv[7][4:0] : wv[8][4:0], g3);
      chk("core3_offset", s ? ext : wv[0][11:0], o3);
      chk("fixed_cores", {wv[1][11:0], wv[2][11:0], wv[3][4:0], wv[4][4:0]}, {o4, o5, g0, g1});
    end
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, idx[3], 32'h0);
    chk("reload_after_reset", {16'h0, fz[3]}, rd);
    chk("core4_after_reload", fz[1][11:0], o4);
    // lane 1 strobe off: that byte must keep its fuse value
    strb = 4'h1;
    apb(1'b1, idx[1], 32'h0000_0055);
    apb(1'b0, idx[1], 32'h0);
    chk("lane0_write", {16'h0, fz[1][15:8], 8'h55}, rd);
    chk("core4_lane0", {fz[1][11:8], 8'h55}, o4);
    close_out();
  end
endmodule : adc_trim_regs_tb

`default_nettype wire
